//--- src/prrp_framer.sv
// Function
// - dword-aligned: payload directly after the descriptor dwords
// - valid dropping inside a packet nullifies that packet's TLP
// - device may drop accept; client then holds all inputs
// - address-aligned: payload next beat, start lane from sideband, lane zero for messages
// - descriptor-only packet: two beats at 64 bit, one wider
// - read start lane picks completion data alignment
// - io/cfg writes use leading mask; atomics that are not also message types treat all bytes valid
// - messages end by final_beat and keep; masks ignored
`timescale 1ns/1ps
`default_nettype none
`include "prrp_consts.svh"
module prrp_framer
   import prrp_pkg::*;
#(
   parameter int FIFO_DEPTH = `PRRP_FIFO_DEPTH,
   parameter logic [15:0] ATOMIC_SET = `PRRP_ATOMIC_SET,
   parameter logic [15:0] MSG_SET = `PRRP_MSG_SET
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic addr_aligned_mode,
   input wire logic request_stream_valid,
   output logic request_stream_accept,
   input wire logic [`PRRP_DATA_W-1:0] request_stream_data,
   input wire logic [`PRRP_DATA_W/32-1:0] request_stream_dword_keep,
   input wire logic request_stream_final_beat,
   input wire prrp_side_s request_stream_sideband,
   output logic link_valid,
   input wire logic link_ready,
   output prrp_entry_s link_beat
);
   localparam int LANES = `PRRP_DATA_W / 32;
   localparam int TYPE_BIT = `PRRP_TYPE_LSB % `PRRP_DATA_W;
   localparam logic [1:0] TYPE_BEAT = 2'(`PRRP_TYPE_LSB / `PRRP_DATA_W);
   localparam logic [2:0] DW_LANE = 3'(`PRRP_DESC_DW % LANES);
   localparam int ENTRY_W = $bits(prrp_entry_s);

   // ==========================================================
   // handshake and framing state
   prrp_state_e state_r;
   logic fire, wr_ready;
   logic [1:0] beat_cnt_r;
   logic err_r;
   logic [`PRRP_TYPE_W-1:0] type_r, type_now;
   prrp_side_s side_r, side_now, side_out;
   logic is_atomic, is_msg;
   prrp_entry_s wr_beat;

   assign request_stream_accept = wr_ready;
   assign fire = request_stream_valid && wr_ready;

   // packet tracking: body means a non-final beat has been taken
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= PRRP_IDLE;
      end else if (fire) begin
         state_r <= request_stream_final_beat ? PRRP_IDLE : PRRP_BODY;
      end
   end

   // beat index saturates; only the first two beats matter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         beat_cnt_r <= '0;
      end else if (fire) begin
         if (request_stream_final_beat) begin
            beat_cnt_r <= '0;
         end else if (beat_cnt_r != 2'h3) begin
            beat_cnt_r <= beat_cnt_r + 2'h1;
         end
      end
   end

   // sticky gap error; no clear can collide since last needs valid high
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         err_r <= 1'b0;
      end else if (state_r == PRRP_BODY && !request_stream_valid) begin
         err_r <= 1'b1;
      end else if (fire && request_stream_final_beat) begin
         err_r <= 1'b0;
      end
   end

   // request type sits in the second beat on a 64-bit datapath
   assign type_now = (beat_cnt_r == TYPE_BEAT) ?
      request_stream_data[TYPE_BIT +: `PRRP_TYPE_W] : type_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         type_r <= '0;
      end else if (fire && beat_cnt_r == TYPE_BEAT) begin
         type_r <= type_now;
      end
   end

   // sideband is only meaningful on the first beat, so hold it
   assign side_now = (state_r == PRRP_IDLE) ?
      request_stream_sideband : side_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         side_r <= '0;
      end else if (fire && state_r == PRRP_IDLE) begin
         side_r <= request_stream_sideband;
      end
   end

   assign is_atomic = ATOMIC_SET[type_now];
   assign is_msg = MSG_SET[type_now];

   // effective masks and start lane handed to the link side
   always_comb begin
      side_out = side_now;
      if (!addr_aligned_mode) begin
         side_out.payload_start_lane = DW_LANE;
      end
      if (is_msg) begin
         side_out.leading_byte_mask = `PRRP_MASK_NONE;
         side_out.trailing_byte_mask = `PRRP_MASK_NONE;
         side_out.payload_start_lane = addr_aligned_mode ?
            `PRRP_LANE_ZERO : DW_LANE;
      end else if (is_atomic) begin
         side_out.leading_byte_mask = `PRRP_MASK_ALL;
         side_out.trailing_byte_mask = `PRRP_MASK_ALL;
      end
   end

   // beat record; nullify rides with the final beat
   always_comb begin
      wr_beat.data = request_stream_data;
      wr_beat.keep = request_stream_dword_keep;
      wr_beat.last = request_stream_final_beat;
      wr_beat.nullify = err_r && request_stream_final_beat;
      wr_beat.is_message = is_msg;
      wr_beat.side = side_out;
   end

   // ==========================================================
   // elastic buffer towards the link; its not-full flag is our accept
   prrp_fifo #(
      .W(ENTRY_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(request_stream_valid),
      .in_ready(wr_ready),
      .in_data(wr_beat),
      .out_valid(link_valid),
      .out_ready(link_ready),
      .out_data(link_beat)
   );

   // ==========================================================
   // checks
   property p_gap_sets_err;
      @(posedge clk) disable iff (!rst_b)
         (state_r == PRRP_BODY && !request_stream_valid) |=> err_r;
   endproperty
   a_gap_sets_err: assert property (p_gap_sets_err)
      else $error("valid gap did not mark packet");

   // error stays armed until the final beat carries it out
   property p_gap_nullifies;
      @(posedge clk) disable iff (!rst_b)
         (err_r && !(fire && request_stream_final_beat)) |=> err_r;
   endproperty
   a_gap_nullifies: assert property (p_gap_nullifies)
      else $error("gap error dropped before final beat");

   property p_clean_not_null;
      @(posedge clk) disable iff (!rst_b)
         (fire && request_stream_final_beat && !err_r) |-> !wr_beat.nullify;
   endproperty
   a_clean_not_null: assert property (p_clean_not_null)
      else $error("clean packet nullified");

   property p_err_then_null;
      @(posedge clk) disable iff (!rst_b)
         (err_r && fire && request_stream_final_beat) |-> wr_beat.nullify;
   endproperty
   a_err_then_null: assert property (p_err_then_null)
      else $error("errored packet not nullified");

   property p_atomic_masks;
      @(posedge clk) disable iff (!rst_b)
         (fire && is_atomic && !is_msg) |->
         wr_beat.side.leading_byte_mask == `PRRP_MASK_ALL &&
         wr_beat.side.trailing_byte_mask == `PRRP_MASK_ALL;
   endproperty
   a_atomic_masks: assert property (p_atomic_masks)
      else $error("atomic masks not all ones");

   property p_msg_masks;
      @(posedge clk) disable iff (!rst_b)
         (fire && is_msg) |-> wr_beat.side.leading_byte_mask == '0 &&
         wr_beat.side.trailing_byte_mask == '0;
   endproperty
   a_msg_masks: assert property (p_msg_masks)
      else $error("message masks not cleared");

   property p_aligned_lane;
      @(posedge clk) disable iff (!rst_b)
         (fire && addr_aligned_mode && !is_msg && state_r == PRRP_BODY) |->
         wr_beat.side.payload_start_lane == $past(side_now.payload_start_lane);
   endproperty
   a_aligned_lane: assert property (p_aligned_lane)
      else $error("start lane not held from first beat");

   property p_dword_lane;
      @(posedge clk) disable iff (!rst_b)
         (fire && !addr_aligned_mode) |->
         wr_beat.side.payload_start_lane == DW_LANE;
   endproperty
   a_dword_lane: assert property (p_dword_lane)
      else $error("dword-aligned payload lane wrong");

   property p_idle_after_last;
      @(posedge clk) disable iff (!rst_b)
         (fire && request_stream_final_beat) |=>
         state_r == PRRP_IDLE && beat_cnt_r == '0;
   endproperty
   a_idle_after_last: assert property (p_idle_after_last)
      else $error("framing not reset after final beat");

   c_single_beat: cover property (@(posedge clk) disable iff (!rst_b)
      state_r == PRRP_IDLE && fire && request_stream_final_beat);
   c_multi_beat: cover property (@(posedge clk) disable iff (!rst_b)
      (fire && !request_stream_final_beat)
      ##1 (fire && request_stream_final_beat));
   c_nullified: cover property (@(posedge clk) disable iff (!rst_b)
      fire && wr_beat.nullify);
   c_message: cover property (@(posedge clk) disable iff (!rst_b)
      fire && is_msg && request_stream_final_beat);
endmodule // prrp_framer
`default_nettype wire

//--- src/prrp_consts.svh
`ifndef PRRP_CONSTS_SVH
`define PRRP_CONSTS_SVH
// ==========================================================
// datapath shape
`define PRRP_DATA_W 256
`define PRRP_FIFO_DEPTH 16
`define PRRP_DESC_DW 4
// ==========================================================
// descriptor field positions
`define PRRP_TYPE_LSB 75
`define PRRP_TYPE_W 4
`define PRRP_COUNT_LSB 64
`define PRRP_COUNT_W 11
// ==========================================================
// byte mask and lane values
`define PRRP_MASK_ALL 4'hF
`define PRRP_MASK_NONE 4'h0
`define PRRP_LANE_ZERO 3'h0
// request type classes, one bit per 4-bit type code (arbitrary defaults)
`define PRRP_ATOMIC_SET 16'h7000
`define PRRP_MSG_SET 16'hC000
`endif

//--- src/prrp_pkg.sv
`include "prrp_consts.svh"
`default_nettype none
package prrp_pkg;
   // ==========================================================
   // sideband carried on the first beat of a packet
   typedef struct packed {
      logic [2:0] payload_start_lane;
      logic [3:0] trailing_byte_mask;
      logic [3:0] leading_byte_mask;
   } prrp_side_s;

   // one beat as stored towards the link side
   typedef struct packed {
      logic [`PRRP_DATA_W-1:0] data;
      logic [`PRRP_DATA_W/32-1:0] keep;
      logic last;
      logic nullify;
      logic is_message;
      prrp_side_s side;
   } prrp_entry_s;

   typedef enum logic [0:0] {
      PRRP_IDLE,
      PRRP_BODY
   } prrp_state_e;
endpackage
`default_nettype wire

//--- src/prrp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module prrp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
   // ==========================================================
   // storage and pointers
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r, rd_ptr_r;
   logic [AW:0] count_r;
   logic push, pop;

   // honest flags; ready drops only when truly full
   assign in_ready = (count_r != FULL);
   assign out_valid = (count_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_r];

   // array write, no reset needed on payload storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // pointer wrap written out so non power-of-two depths work
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // ==========================================================
   // checks
   property p_ready_only_full;
      @(posedge clk) disable iff (!rst_b) !in_ready |-> count_r == FULL;
   endproperty
   a_ready_only_full: assert property (p_ready_only_full)
      else $error("accept withdrawn while fifo not full");

   property p_count_step;
      @(posedge clk) disable iff (!rst_b)
         (in_valid && in_ready && !pop) |=> count_r == $past(count_r) + 1'b1;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("transferred beat not counted");

   property p_fill_up;
      @(posedge clk) disable iff (!rst_b) !in_ready;
   endproperty
   c_fill_up: cover property (p_fill_up);
endmodule // prrp_fifo
`default_nettype wire

//--- testbench/prrp_client.sv
`timescale 1ns/1ps
`default_nettype none
`include "prrp_consts.svh"
// ==========================================================
// client model: offers beats, holds them while refused
module prrp_client
   import prrp_pkg::*;
(
   input wire logic clk,
   input wire logic accept,
   output logic valid,
   output logic [`PRRP_DATA_W-1:0] data,
   output logic [7:0] keep,
   output logic final_beat,
   output prrp_side_s side,
   output logic hung
);
   // idle lines at time zero
   initial begin
      valid = 1'b0;
      data = '0;
      keep = 8'h00;
      final_beat = 1'b0;
      side = '0;
      hung = 1'b0;
   end

   // one beat, entered just after a rising edge; held until taken
   task automatic beat(input logic [`PRRP_DATA_W-1:0] d,
         input logic [7:0] k, input logic f, input prrp_side_s s);
      int n;
      valid <= 1'b1;
      data <= d;
      keep <= k;
      final_beat <= f;
      side <= s;
      n = 0;
      // accept only moves on rising edges, so the falling edge is safe
      do begin
         @(negedge clk);
         n++;
      end while (accept !== 1'b1 && n < 400);
      if (accept !== 1'b1)
         hung <= 1'b1;
      @(posedge clk);
   endtask

   // released data and keep show junk, never the last beat
   task automatic gap();
      valid <= 1'b0;
      data <= ~data;
      keep <= ~keep;
      @(posedge clk);
   endtask
endmodule // prrp_client
`default_nettype wire

//--- testbench/test_prrp_framer.sv
`timescale 1ns/1ps
`default_nettype none
`include "prrp_consts.svh"
module test_prrp_framer
   import prrp_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic mode = 1'b0;
   logic link_ready = 1'b0;
   logic valid, accept, fin, link_valid, hung;
   logic [`PRRP_DATA_W-1:0] data;
   logic [7:0] keep;
   prrp_side_s side;
   prrp_entry_s link_beat;
   prrp_side_s s0 = '{3'h1, 4'hC, 4'h3};
   prrp_side_s e0 = '{3'h4, 4'hC, 4'h3};
   int bad_count = 0;
   int num_checks = 0;

   always #2.5 clk = ~clk;

   prrp_client cli (.clk(clk), .accept(accept), .valid(valid),
      .data(data), .keep(keep), .final_beat(fin), .side(side),
      .hung(hung));

   // small fifo so a fill takes few beats; type 4 atomic, type 5 message
   prrp_framer #(.FIFO_DEPTH(4), .ATOMIC_SET(16'h0010),
      .MSG_SET(16'h0020)) uut (.clk(clk), .rst_b(rst_b),
      .addr_aligned_mode(mode), .request_stream_valid(valid),
      .request_stream_accept(accept), .request_stream_data(data),
      .request_stream_dword_keep(keep), .request_stream_final_beat(fin),
      .request_stream_sideband(side), .link_valid(link_valid),
      .link_ready(link_ready), .link_beat(link_beat));

   // ==========================================================
   // helpers
   // descriptor beat: filler bytes, request type and dword count
   function automatic logic [`PRRP_DATA_W-1:0] desc(input logic [3:0] t,
         input logic [7:0] n, input logic [`PRRP_COUNT_W-1:0] c = 11'h001);
      logic [`PRRP_DATA_W-1:0] d;
      d = {32{n}};
      d[`PRRP_TYPE_LSB +: `PRRP_TYPE_W] = t;
      d[`PRRP_COUNT_LSB +: `PRRP_COUNT_W] = c;
      return d;
   endfunction

   // flags are {last, nullify, is_message}
   function automatic prrp_entry_s ent(input logic [`PRRP_DATA_W-1:0] d,
         input logic [7:0] k, input logic [2:0] fl, input prrp_side_s s);
      prrp_entry_s e;
      e.data = d;
      e.keep = k;
      {e.last, e.nullify, e.is_message} = fl;
      e.side = s;
      return e;
   endfunction

   task automatic chk(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask

   // wait for the head entry, compare it, then pop it with one ready
   task automatic pop(input prrp_entry_s e);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (link_valid !== 1'b1 && n < 50);
      num_checks++;
      if (link_valid !== 1'b1) begin
         bad_count++;
         $display("wrong value link_valid expected 1 seen %b", link_valid);
         final_report();
      end else begin
         if (link_beat !== e) begin
            bad_count++;
            $display("wrong value link_beat expected %h seen %h", e,
               link_beat);
         end
         @(posedge clk);
         link_ready <= 1'b1;
         @(posedge clk);
         link_ready <= 1'b0;
      end
   endtask

   task automatic final_report();
      if (hung === 1'b1)
         bad_count++;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   // read then a seven-dword write, back to back; second side is junk
   task automatic t_dword();
      prrp_side_s wr_s, wr_e;
      wr_s = '{3'h2, 4'hE, 4'h7};
      wr_e = '{3'h4, 4'hE, 4'h7};
      cli.beat(desc(4'h0, 8'h11), 8'h0F, 1'h1, s0);
      cli.beat(desc(4'h1, 8'h22, 11'h007), 8'hFF, 1'h0,
         wr_s);
      cli.beat(desc(4'h1, 8'h33), 8'h07, 1'h1,
         '{3'h5, 4'h1, 4'h1});
      cli.gap();
      pop(ent(desc(4'h0, 8'h11), 8'h0F, 3'h4, e0));
      pop(ent(desc(4'h1, 8'h22, 11'h007), 8'hFF, 3'h0,
         wr_e));
      pop(ent(desc(4'h1, 8'h33), 8'h07, 3'h4, wr_e));
   endtask

   // valid drops inside an atomic; a clean zero-length write follows
   task automatic t_gap();
      prrp_side_s at_e, zl_s, zl_e;
      at_e = '{3'h4, 4'hF, 4'hF};
      zl_s = '{3'h0, 4'h0, 4'h0};
      zl_e = '{3'h4, 4'h0, 4'h0};
      cli.beat(desc(4'h4, 8'h44), 8'hFF, 1'h0, s0);
      cli.gap();
      cli.beat(desc(4'h4, 8'h55), 8'h01, 1'h1, s0);
      cli.beat(desc(4'h1, 8'h66), 8'h1F, 1'h1, zl_s);
      cli.gap();
      pop(ent(desc(4'h4, 8'h44), 8'hFF, 3'h0, at_e));
      pop(ent(desc(4'h4, 8'h55), 8'h01, 3'h6, at_e));
      pop(ent(desc(4'h1, 8'h66), 8'h1F, 3'h4, zl_e));
   endtask

   // link side stalls: fifo fills, accept drops, order kept on drain
   task automatic t_fill();
      fork
         begin
            for (int i = 0; i < 5; i++)
               cli.beat(desc(4'h0, 8'(i)), 8'h0F, 1'h1, s0);
            cli.gap();
         end
         begin
            repeat (10) @(negedge clk);
            chk("accept", 1'b0, accept);
            @(posedge clk);
            for (int i = 0; i < 5; i++)
               pop(ent(desc(4'h0, 8'(i)), 8'h0F, 3'h4, e0));
         end
      join
   endtask

   // address-aligned: message, atomic, zero-length read with client lane
   task automatic t_addr();
      prrp_side_s ms_s, at_s, at_e, rd_s;
      ms_s = '{3'h0, 4'h5, 4'hA};
      at_s = '{3'h2, 4'h1, 4'h8};
      at_e = '{3'h2, 4'hF, 4'hF};
      rd_s = '{3'h6, 4'h0, 4'h0};
      mode <= 1'b1;
      cli.beat(desc(4'h5, 8'h77), 8'h0F, 1'h0, ms_s);
      cli.beat(desc(4'h5, 8'h88), 8'h03, 1'h1, ms_s);
      cli.beat(desc(4'h4, 8'h99), 8'h0F, 1'h0, at_s);
      cli.beat(desc(4'h4, 8'hAA), 8'h3C, 1'h1, at_s);
      cli.gap();
      pop(ent(desc(4'h5, 8'h77), 8'h0F, 3'h1, '0));
      pop(ent(desc(4'h5, 8'h88), 8'h03, 3'h5, '0));
      pop(ent(desc(4'h4, 8'h99), 8'h0F, 3'h0, at_e));
      pop(ent(desc(4'h4, 8'hAA), 8'h3C, 3'h4, at_e));
      cli.beat(desc(4'h0, 8'hBB), 8'h0F, 1'h1, rd_s);
      cli.gap();
      pop(ent(desc(4'h0, 8'hBB), 8'h0F, 3'h4, rd_s));
      mode <= 1'b0;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("accept", 1'b1, accept);
      chk("link_valid", 1'b0, link_valid);
      @(posedge clk);
      t_dword();
      t_gap();
      t_fill();
      t_addr();
      final_report();
   end
endmodule // test_prrp_framer
`default_nettype wire
